/* File: rtl/bms_regs.vh */
`ifndef BMS_REGS_VH
`define BMS_REGS_VH

// Boot select codes on the two strap pins
`define BMS_CODE_PAR   2'h0
`define BMS_CODE_FSER  2'h1
`define BMS_CODE_SPI   2'h2
`define BMS_CODE_EEP   2'h3

// Boot procedure length
`define BMS_BOOT_TIME_NS   3000000
`define BMS_CLK_PERIOD_NS  4
`define BMS_BOOT_CYCLES    (`BMS_BOOT_TIME_NS / `BMS_CLK_PERIOD_NS)

// Pin indices within the 32-bit general purpose pin group
`define BMS_PIN_SEL_HI  31
`define BMS_PIN_SEL_LO  30
`define BMS_PIN_OTG     29
`define BMS_PIN_DBG_HI  28
`define BMS_PIN_DBG_LO  27

// Pin output enable reset value: all inputs
`define BMS_OE_RESET  32'h00000000

`endif

/* File: rtl/bms_boot_select.v */
`timescale 1ns/100ps
`include "bms_regs.vh"
// Functional notes
// - Boot mode comes from the two boot select pins as seen when reset is released.
// - Codes 00 parallel port, 01 fast serial port, 10 serial peripheral slave, 11 standalone.
// - Every reset runs a boot procedure lasting no more than three milliseconds.
// - Select pins are sampled only in the first cycle after reset release, before boot, and are free as general pins after boot.
// - Non-standalone codes enable only the chosen interface and wait idle for the host.
// - Rates are 16-bit parallel up to 16 MB/s, fast serial up to 2M baud, slave serial up to 2 Mb/s.
// - In standalone mode the internal processor loads firmware from EEPROM or optionally USB.
// - After a standalone boot both select pins become outputs for the EEPROM interface.
// - After a standalone boot pins 28 and 27 carry the debug serial port.
// - After a standalone boot pin 29 is the OTG role input, high peripheral, low host.
// - After a standalone boot the other three USB ports are peripherals and other pins stay inputs.
// - The clock select strap is sampled after reset, high meaning the 12 MHz reference.
// - Reset returns every register to its default before sampling and boot start.
module bms_boot_select #(
  parameter BOOT_CYCLES = `BMS_BOOT_CYCLES
) (
  input  wire        i_mclk,
  input  wire        i_rstn,
  input  wire [31:0] i_gpio,
  input  wire        i_clock_select_strap,
  input  wire        i_usb_fw_load,
  output reg  [1:0]  o_boot_mode,
  output reg         o_boot_busy,
  output reg         o_boot_done,
  output reg         o_coproc_mode,
  output reg         o_standalone,
  output reg         o_parallel_host_port_en,
  output reg         o_fast_serial_port_en,
  output reg         o_spi_slave_en,
  output reg         o_eeprom_load_en,
  output reg         o_usb_load_en,
  output reg         o_ref_12mhz,
  output reg         o_sel_pins_free,
  output reg  [31:0] o_gpio_oe,
  output reg         o_debug_uart_en,
  output reg         o_otg_port_a_peripheral,
  output reg         o_otg_port_a_host,
  output reg  [2:0]  o_other_ports_peripheral
);

  localparam ST_RESET = 2'h0;
  localparam ST_BOOT  = 2'h1;
  localparam ST_RUN   = 2'h2;

  // Counter is 22 bits, enough for the full 3 ms count
  localparam [31:0] BOOT_LAST_W = BOOT_CYCLES - 1;
  localparam [21:0] BOOT_LAST   = BOOT_LAST_W[21:0];

  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [21:0] cnt_ff;
  reg [21:0] nxt_cnt;
  reg [1:0]  mode_ff;
  reg        clk12_ff;

  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= ST_RESET;
      cnt_ff   <= 22'h000000;
      mode_ff  <= `BMS_CODE_PAR;
      clk12_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (state_ff == ST_RESET) begin
        mode_ff  <= {i_gpio[`BMS_PIN_SEL_HI], i_gpio[`BMS_PIN_SEL_LO]};
        clk12_ff <= i_clock_select_strap;
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_RESET: begin
        nxt_state = ST_BOOT;
        nxt_cnt   = 22'h000000;
      end
      ST_BOOT: begin
        if (cnt_ff >= BOOT_LAST) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + 22'h000001;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  wire run_w  = (state_ff == ST_RUN);
  wire sa_w   = (mode_ff == `BMS_CODE_EEP);
  wire up_w   = (state_ff != ST_RESET);

  // Outputs registered so nothing glitches during decode
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_boot_mode              <= `BMS_CODE_PAR;
      o_boot_busy              <= 1'b0;
      o_boot_done              <= 1'b0;
      o_coproc_mode            <= 1'b0;
      o_standalone             <= 1'b0;
      o_parallel_host_port_en  <= 1'b0;
      o_fast_serial_port_en    <= 1'b0;
      o_spi_slave_en           <= 1'b0;
      o_eeprom_load_en         <= 1'b0;
      o_usb_load_en            <= 1'b0;
      o_ref_12mhz              <= 1'b0;
      o_sel_pins_free          <= 1'b0;
      o_gpio_oe                <= `BMS_OE_RESET;
      o_debug_uart_en          <= 1'b0;
      o_otg_port_a_peripheral  <= 1'b0;
      o_otg_port_a_host        <= 1'b0;
      o_other_ports_peripheral <= 3'h0;
    end else begin
      o_boot_mode   <= mode_ff;
      o_boot_busy   <= (state_ff == ST_BOOT);
      o_boot_done   <= run_w;
      o_ref_12mhz   <= clk12_ff;
      // decode; one interface only, rates set by those ports
      o_coproc_mode           <= up_w & ~sa_w;
      o_standalone            <= up_w & sa_w;
      o_parallel_host_port_en <= up_w & (mode_ff == `BMS_CODE_PAR);
      o_fast_serial_port_en   <= up_w & (mode_ff == `BMS_CODE_FSER);
      o_spi_slave_en          <= up_w & (mode_ff == `BMS_CODE_SPI);
      o_eeprom_load_en <= run_w & sa_w;
      o_usb_load_en    <= run_w & sa_w & i_usb_fw_load;
      o_sel_pins_free  <= run_w;
      // select pins drive EEPROM; rest stay inputs
      o_gpio_oe <= `BMS_OE_RESET;
      if (run_w && sa_w) begin
        o_gpio_oe[`BMS_PIN_SEL_HI] <= 1'b1;
        o_gpio_oe[`BMS_PIN_SEL_LO] <= 1'b1;
      end
      o_debug_uart_en <= run_w & sa_w;
      o_otg_port_a_peripheral <= run_w & sa_w & i_gpio[`BMS_PIN_OTG];
      o_otg_port_a_host       <= run_w & sa_w & ~i_gpio[`BMS_PIN_OTG];
      o_other_ports_peripheral <= {3{run_w & sa_w}};
    end
  end

endmodule // bms_boot_select

/* File: tb/bms_boot_select_assertions.sv */
`timescale 1ns/100ps
module bms_chk #(parameter BOOT_CYCLES = 8) (
  input wire        i_mclk, i_rstn, o_boot_busy, o_boot_done, o_coproc_mode, o_standalone,
  input wire        o_spi_slave_en, o_debug_uart_en, o_sel_pins_free,
  input wire [1:0]  o_boot_mode,
  input wire [31:0] o_gpio_oe);
  localparam int LO = BOOT_CYCLES;
  localparam int HI = BOOT_CYCLES + 2;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_spi_code: assert property (o_coproc_mode |-> o_spi_slave_en == (o_boot_mode == 2'h2)) else $error("spi");
  a_mode_split: assert property (o_boot_busy |-> o_standalone == &o_boot_mode) else $error("mode");
  a_one_mode: assert property (o_boot_busy |-> o_coproc_mode != o_standalone) else $error("pair");
  a_mode_hold: assert property (o_boot_done |=> $stable(o_boot_mode)) else $error("moved");
  a_oe_pins: assert property (o_gpio_oe == {{2{o_standalone && o_boot_done}}, 30'h0}) else $error("oe");
  a_dbg_uart: assert property (o_debug_uart_en == (o_standalone && o_boot_done)) else $error("uart");
  a_boot_len: assert property ($rose(o_boot_busy) |-> ##[LO:HI] $rose(o_boot_done)) else $error("time");
  a_pins_free: assert property (o_sel_pins_free == o_boot_done) else $error("pins");
  cover property (o_standalone && o_boot_done);
  cover property (o_spi_slave_en);
  cover property ($rose(o_boot_done));
endmodule // bms_chk
bind bms_boot_select bms_chk #(.BOOT_CYCLES(BOOT_CYCLES)) u_chk (.*);

/* File: tb/bms_pin_model.sv */
`timescale 1ns/100ps
module bms_pin_model (input wire [1:0] i_code, input wire i_otg, input wire [31:0] i_oe, i_noise,
  output wire [31:0] o_gpio);
  // strap levels; pull-ups win while driven
  assign o_gpio = {i_oe[31:30] | i_code, i_otg, i_noise[28:0]};
endmodule // bms_pin_model

/* File: tb/bms_boot_select_bench.sv */
`timescale 1ns/100ps
module bms_boot_select_bench;
  reg i_mclk = 1'b0, i_rstn = 1'b0, i_clock_select_strap = 1'b0, i_usb_fw_load = 1'b0, otg = 1'b0, s;
  reg [1:0] m = 2'h0, code = 2'h0;
  reg [31:0] rng = 32'h00005865, cyc = 32'h0;
  wire [31:0] i_gpio, o_gpio_oe;
  wire [2:0] o_other_ports_peripheral;
  wire [1:0] o_boot_mode;
  wire o_boot_busy, o_boot_done, o_coproc_mode, o_standalone, o_parallel_host_port_en, o_fast_serial_port_en,
    o_spi_slave_en, o_eeprom_load_en, o_usb_load_en, o_ref_12mhz, o_sel_pins_free, o_debug_uart_en,
    o_otg_port_a_peripheral, o_otg_port_a_host;
  integer n_fail = 0, n_tests = 0, k, w;
  always #2 i_mclk = ~i_mclk;
  bms_pin_model pins (.i_code(code), .i_otg(otg), .i_oe(o_gpio_oe), .i_noise(rng), .o_gpio(i_gpio));
  bms_boot_select #(.BOOT_CYCLES(8)) dut (.*);
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    return xs ^ (xs << 5);
  endfunction
  task summarize;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input [31:0] g, e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  always @(posedge i_mclk) begin
    rng <= xs(rng);
    cyc <= cyc + 32'h1;
    if (cyc == 32'h400) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  initial begin
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge i_mclk);
      m = k[1:0];
      s = rng[9];
      {i_rstn, code, i_clock_select_strap, otg, i_usb_fw_load} <= {1'b0, m, s, rng[4:3]};
      // reset held low, shortened for simulation
      repeat (3) @(posedge i_mclk);
      i_rstn <= 1'b1;
      repeat (2) @(posedge i_mclk);
      // Straps flip once captured
      {code, i_clock_select_strap} <= ~{m, s};
      // host side waits for the whole boot before talking
      for (w = 0; w < 30 && o_boot_done !== 1'b1; w = w + 1) @(posedge i_mclk) #1;
      @(posedge i_mclk) #1;
      check({o_boot_mode, o_coproc_mode, o_standalone, o_boot_busy}, {m, ~&m, &m, 1'b0});
      check({o_spi_slave_en, o_fast_serial_port_en, o_parallel_host_port_en}, &m ? 3'h0 : 3'h1 << m);
      check({o_ref_12mhz, o_debug_uart_en, o_other_ports_peripheral, o_gpio_oe[31:20]},
        {s, {4{&m}}, {2{&m}}, 10'h0});
      check({o_otg_port_a_peripheral, o_otg_port_a_host, o_usb_load_en, o_eeprom_load_en, o_sel_pins_free},
        {&m & otg, &m & ~otg, &m & i_usb_fw_load, &m, 1'b1});
    end
    summarize;
  end
endmodule // bms_boot_select_bench
